// ---- pkg/ssxs_pkg.sv ----
/*
 * Constants, types and helpers for the subtract / swap / xor / sleep execution
 * datapath. Assumes a single 200 MHz core clock and an Avalon-MM host.
 */
// How it works
// - Literal-minus-acc writes the immediate minus the accumulator back into the accumulator.
// - Literal-minus-acc clears carry if acc > literal, clears nibble carry on low nibbles.
// - Sleep reloads the watchdog counter with zero and clears its prescaler.
// - Sleep clears the power-down flag, sets the time-out bit, leaves carry, nibble carry and zero alone.
// - After sleep the core stays asleep and executes no instruction until woken.
// - File-minus-acc computes the addressed file register minus the accumulator.
// - File-minus-acc sets carry and nibble carry as unsigned no-borrow compares.
// - Destination bit 0 sends a file result to the accumulator, 1 back to the file.
// - File-minus-acc-borrow also subtracts the inverse of carry and updates carry, nibble carry and zero.
// - Nibble exchange swaps the two halves of the file value and leaves flags alone.
// - Literal-xor-acc stores acc xor literal in the accumulator, updating only zero.
// - Direction load copies the accumulator to port A, B or C direction for 5, 6, 7.
// - File-xor-acc routes acc xor file by the destination bit, updating only zero.
package ssxs_pkg;

    localparam int unsigned BUS_DW     = 32;
    localparam int unsigned ADDR_W     = 10;
    localparam int unsigned FILE_DEPTH = 128;

    // Byte addresses of the register map
    localparam logic [9:0] ADDR_CMD       = 10'h000;
    localparam logic [9:0] ADDR_ACC       = 10'h004;
    localparam logic [9:0] ADDR_STATUS    = 10'h008;
    localparam logic [9:0] ADDR_WDT_CTRL  = 10'h00C;
    localparam logic [9:0] ADDR_WDT_COUNT = 10'h010;
    localparam logic [9:0] ADDR_DIR       = 10'h014;
    localparam logic [9:0] ADDR_FILE_BASE = 10'h200;

    // Opcodes in the command register
    localparam logic [3:0] OP_NOP          = 4'h0;
    localparam logic [3:0] OP_LIT_MINUS    = 4'h1;
    localparam logic [3:0] OP_FILE_MINUS   = 4'h2;
    localparam logic [3:0] OP_FILE_MINUS_B = 4'h3;
    localparam logic [3:0] OP_NIBBLE_EX    = 4'h4;
    localparam logic [3:0] OP_LIT_XOR      = 4'h5;
    localparam logic [3:0] OP_FILE_XOR     = 4'h6;
    localparam logic [3:0] OP_DIR_LOAD     = 4'h7;
    localparam logic [3:0] OP_SLEEP        = 4'h8;

    // Direction-load operand values
    localparam logic [6:0] DIR_SEL_A = 7'h05;
    localparam logic [6:0] DIR_SEL_B = 7'h06;
    localparam logic [6:0] DIR_SEL_C = 7'h07;

    // Field positions
    localparam int unsigned STAT_C_BIT    = 0;
    localparam int unsigned STAT_DC_BIT   = 1;
    localparam int unsigned STAT_Z_BIT    = 2;
    localparam int unsigned STAT_PDN_BIT  = 3;
    localparam int unsigned STAT_TON_BIT  = 4;
    localparam int unsigned STAT_SLP_BIT  = 5;
    localparam int unsigned WDT_EN_BIT    = 0;
    localparam int unsigned WDT_CLR_BIT   = 1;

    // Reset values
    localparam logic [7:0] ACC_RST     = 8'h00;
    localparam logic [7:0] DIR_RST     = 8'hFF;
    localparam logic [7:0] FILE_RST    = 8'h00;
    localparam logic [7:0] WDT_LOAD    = 8'h00;
    localparam logic [7:0] WDT_TOP     = 8'hFF;
    localparam logic [3:0] BORROW_NONE = 4'h0;

    // Watchdog prescaler: one counter tick per this many core cycles
    localparam int unsigned WDT_PRESCALE_DEF = 256;

    typedef struct packed {
        logic [3:0] op;
        logic       dest;
        logic [6:0] faddr;
        logic [7:0] lit;
    } ssxs_cmd_s;

    typedef struct packed {
        logic to_n;
        logic pd_n;
        logic z;
        logic dc;
        logic c;
    } ssxs_status_s;

    typedef struct packed {
        logic [7:0] res;
        logic       c;
        logic       dc;
    } ssxs_sub_s;

    typedef enum logic {
        SSXS_RUN,
        SSXS_ASLEEP
    } ssxs_pwr_e;

    // a - b - (1 - cin); carry and nibble carry are the no-borrow outputs
    function automatic ssxs_sub_s ssxs_sub(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin);
        logic [8:0] full;
        logic [4:0] low;
        ssxs_sub_s  r;
        full  = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
        low   = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
        r.res = full[7:0];
        r.c   = full[8];
        r.dc  = low[4];
        return r;
    endfunction : ssxs_sub

    // Merge a bus write into a word under byte enables
    function automatic logic [31:0] ssxs_be_merge(input logic [31:0] old_w,
                                                  input logic [31:0] new_w,
                                                  input logic [3:0]  be);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return r;
    endfunction : ssxs_be_merge

endpackage : ssxs_pkg

// ---- hdl/ssxs_exec.sv ----
/*
 * Execution datapath for subtract, nibble exchange, xor, direction load and
 * sleep, with accumulator, status, file registers and watchdog, reached over
 * an Avalon-MM slave with waitrequest. Assumes the host holds each request
 * until waitrequest is low; i_wake comes from a pin and is synchronised here.
 */
`timescale 1ns/10ps
module ssxs_exec
    import ssxs_pkg::*;
#(
    parameter int unsigned WDT_PRESCALE = WDT_PRESCALE_DEF
) (
    input  wire logic                i_clk_sys,
    input  wire logic                i_nrst,
    input  wire logic                i_clk_en,
    input  wire logic [ADDR_W-1:0]   i_avs_address,
    input  wire logic                i_avs_read,
    input  wire logic                i_avs_write,
    input  wire logic [BUS_DW-1:0]   i_avs_writedata,
    input  wire logic [3:0]          i_avs_byteenable,
    output logic      [BUS_DW-1:0]   o_avs_readdata,
    output logic                     o_avs_waitrequest,
    input  wire logic                i_wake,
    output logic                     o_sleep,
    output logic      [7:0]          o_port_a_direction,
    output logic      [7:0]          o_port_b_direction,
    output logic      [7:0]          o_port_c_direction,
    output logic                     o_wdt_timeout
);

    if (WDT_PRESCALE < 1 || WDT_PRESCALE > 65536) begin : g_chk_prescale
        $error("WDT_PRESCALE must lie between 1 and 65536");
    end

    localparam logic [15:0] PRESCALE_LAST = 16'(WDT_PRESCALE - 1);

    // Bus handshake state
    logic               ack_q;
    logic               req;
    logic               wr_fire;
    logic [BUS_DW-1:0]  next_readdata;

    // Architectural state
    logic [7:0]         acc;
    ssxs_status_s       status;
    ssxs_cmd_s          last_cmd;
    logic [7:0]         file_mem [FILE_DEPTH];
    logic [7:0]         port_a_direction;
    logic [7:0]         port_b_direction;
    logic [7:0]         port_c_direction;
    ssxs_pwr_e          pwr_state;

    // Watchdog
    logic               wdt_en;
    logic [15:0]        wdt_prescaler;
    logic [7:0]         watchdog_counter;
    logic               wdt_tick;
    logic               wdt_expire;

    // Wake pin synchroniser
    logic               wake_meta;
    logic               wake_sync;

    // Decoded command and its effects
    ssxs_cmd_s          cmd;
    logic               exec;
    logic [7:0]         file_val;
    ssxs_sub_s          sub_r;
    logic [7:0]         result;
    logic               res_valid;
    logic               to_file;
    logic               upd_c_dc;
    logic               upd_z;
    logic               do_sleep;
    logic               do_dir;
    logic               sw_wdt_clr;
    logic               is_file_addr;
    logic [6:0]         bus_findex;

    assign req               = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~ack_q;
    assign wr_fire           = i_clk_en & i_avs_write & ack_q;

    assign is_file_addr = (i_avs_address >= ADDR_FILE_BASE);
    assign bus_findex   = 7'(({22'h0, i_avs_address} - {22'h0, ADDR_FILE_BASE}) >> 2);

    // One wait state: the request is taken at the second edge it is seen
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            ack_q <= 1'b0;
        end else if (i_clk_en) begin
            ack_q <= req & ~ack_q;
        end
    end

    // Read mux, sampled in the wait cycle so data stand when waitrequest drops
    always_comb begin
        next_readdata = '0;
        if (is_file_addr) begin
            next_readdata = {24'h0, file_mem[bus_findex]};
        end else begin
            case (i_avs_address)
                ADDR_CMD:       next_readdata = {12'h0, last_cmd};
                ADDR_ACC:       next_readdata = {24'h0, acc};
                ADDR_STATUS:    next_readdata = {26'h0, (pwr_state == SSXS_ASLEEP), status};
                ADDR_WDT_CTRL:  next_readdata = {31'h0, wdt_en};
                ADDR_WDT_COUNT: next_readdata = {8'h0, wdt_prescaler, watchdog_counter};
                ADDR_DIR:       next_readdata = {8'h0, port_c_direction,
                                                 port_b_direction, port_a_direction};
                default:        next_readdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_avs_readdata <= '0;
        end else if (i_clk_en && i_avs_read && !ack_q) begin
            o_avs_readdata <= next_readdata;
        end
    end

    // Command word as merged by the byte enables of the current write
    assign cmd  = ssxs_cmd_s'(20'(ssxs_be_merge({12'h0, last_cmd}, i_avs_writedata,
                                                 i_avs_byteenable)));
    assign exec = wr_fire && !is_file_addr && (i_avs_address == ADDR_CMD)
                  && (pwr_state == SSXS_RUN);

    assign file_val   = file_mem[cmd.faddr];
    assign sw_wdt_clr = wr_fire && !is_file_addr && (i_avs_address == ADDR_WDT_CTRL)
                        && i_avs_byteenable[0] && i_avs_writedata[WDT_CLR_BIT];

    // Operation decode and ALU
    always_comb begin
        sub_r     = '0;
        result    = '0;
        res_valid = 1'b0;
        to_file   = 1'b0;
        upd_c_dc  = 1'b0;
        upd_z     = 1'b0;
        do_sleep  = 1'b0;
        do_dir    = 1'b0;
        case (cmd.op)
            OP_LIT_MINUS: begin
                sub_r     = ssxs_sub(cmd.lit, acc, 1'b1);
                result    = sub_r.res;
                res_valid = 1'b1;
                upd_c_dc  = 1'b1;
                upd_z     = 1'b1;
            end
            OP_FILE_MINUS: begin
                sub_r     = ssxs_sub(file_val, acc, 1'b1);
                result    = sub_r.res;
                res_valid = 1'b1;
                to_file   = cmd.dest;
                upd_c_dc  = 1'b1;
                upd_z     = 1'b1;
            end
            OP_FILE_MINUS_B: begin
                sub_r     = ssxs_sub(file_val, acc, status.c);
                result    = sub_r.res;
                res_valid = 1'b1;
                to_file   = cmd.dest;
                upd_c_dc  = 1'b1;
                upd_z     = 1'b1;
            end
            OP_NIBBLE_EX: begin
                result    = {file_val[3:0], file_val[7:4]};
                res_valid = 1'b1;
                to_file   = cmd.dest;
            end
            OP_LIT_XOR: begin
                result    = acc ^ cmd.lit;
                res_valid = 1'b1;
                upd_z     = 1'b1;
            end
            OP_FILE_XOR: begin
                result    = acc ^ file_val;
                res_valid = 1'b1;
                to_file   = cmd.dest;
                upd_z     = 1'b1;
            end
            OP_DIR_LOAD: begin
                do_dir = 1'b1;
            end
            OP_SLEEP: begin
                do_sleep = 1'b1;
            end
            default: begin
                res_valid = 1'b0;
            end
        endcase
    end

    // Accumulator: command results or direct software load
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            acc <= ACC_RST;
        end else if (i_clk_en) begin
            if (exec && res_valid && !to_file) begin
                acc <= result;
            end else if (wr_fire && !is_file_addr && (i_avs_address == ADDR_ACC)
                         && i_avs_byteenable[0]) begin
                acc <= i_avs_writedata[7:0];
            end
        end
    end

    // Last command, readable for software
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            last_cmd <= '0;
        end else if (i_clk_en && wr_fire && !is_file_addr && (i_avs_address == ADDR_CMD)) begin
            last_cmd <= cmd;
        end
    end

    // File registers: command write-back or software access
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < FILE_DEPTH; i++) begin
                file_mem[i] <= FILE_RST;
            end
        end else if (i_clk_en) begin
            if (exec && res_valid && to_file) begin
                file_mem[cmd.faddr] <= result;
            end else if (wr_fire && is_file_addr && i_avs_byteenable[0]) begin
                file_mem[bus_findex] <= i_avs_writedata[7:0];
            end
        end
    end

    // Status flags; hardware events are applied after software writes
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            status <= '{to_n: 1'b1, pd_n: 1'b1, z: 1'b0, dc: 1'b0, c: 1'b0};
        end else if (i_clk_en) begin
            if (wr_fire && !is_file_addr && (i_avs_address == ADDR_STATUS)
                && i_avs_byteenable[0]) begin
                status.c  <= i_avs_writedata[STAT_C_BIT];
                status.dc <= i_avs_writedata[STAT_DC_BIT];
                status.z  <= i_avs_writedata[STAT_Z_BIT];
            end
            if (exec && upd_c_dc) begin
                status.c  <= sub_r.c;
                status.dc <= sub_r.dc;
            end
            if (exec && upd_z) begin
                status.z <= (result == 8'h00);
            end
            if (wdt_expire) begin
                status.to_n <= 1'b0;
            end
            if (exec && do_sleep) begin
                status.pd_n <= 1'b0;
                status.to_n <= 1'b1;
            end
        end
    end

    // Port direction registers
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            port_a_direction <= DIR_RST;
            port_b_direction <= DIR_RST;
            port_c_direction <= DIR_RST;
        end else if (i_clk_en && exec && do_dir) begin
            case (cmd.faddr)
                DIR_SEL_A: port_a_direction <= acc;
                DIR_SEL_B: port_b_direction <= acc;
                DIR_SEL_C: port_c_direction <= acc;
                default:   port_a_direction <= port_a_direction;
            endcase
        end
    end

    assign o_port_a_direction = port_a_direction;
    assign o_port_b_direction = port_b_direction;
    assign o_port_c_direction = port_c_direction;

    // Wake pin synchroniser
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            wake_meta <= 1'b0;
            wake_sync <= 1'b0;
        end else if (i_clk_en) begin
            wake_meta <= i_wake;
            wake_sync <= wake_meta;
        end
    end

    // Sleep state: entered by the sleep command, left by wake or watchdog expiry
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            pwr_state <= SSXS_RUN;
        end else if (i_clk_en) begin
            case (pwr_state)
                SSXS_RUN: begin
                    if (exec && do_sleep) begin
                        pwr_state <= SSXS_ASLEEP;
                    end
                end
                SSXS_ASLEEP: begin
                    if (wake_sync || wdt_expire) begin
                        pwr_state <= SSXS_RUN;
                    end
                end
                default: pwr_state <= SSXS_RUN;
            endcase
        end
    end

    assign o_sleep = (pwr_state == SSXS_ASLEEP);

    // Watchdog enable
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            wdt_en <= 1'b0;
        end else if (i_clk_en && wr_fire && !is_file_addr
                     && (i_avs_address == ADDR_WDT_CTRL) && i_avs_byteenable[0]) begin
            wdt_en <= i_avs_writedata[WDT_EN_BIT];
        end
    end

    // Watchdog prescaler and counter; expiry is a one-cycle event
    assign wdt_tick   = wdt_en && (wdt_prescaler == PRESCALE_LAST);
    assign wdt_expire = i_clk_en && wdt_tick && (watchdog_counter == WDT_TOP)
                        && !(exec && do_sleep) && !sw_wdt_clr;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            wdt_prescaler    <= '0;
            watchdog_counter <= WDT_LOAD;
        end else if (i_clk_en) begin
            if ((exec && do_sleep) || sw_wdt_clr) begin
                wdt_prescaler    <= '0;
                watchdog_counter <= WDT_LOAD;
            end else if (wdt_en) begin
                if (wdt_tick) begin
                    wdt_prescaler    <= '0;
                    watchdog_counter <= watchdog_counter + 8'h01;
                end else begin
                    wdt_prescaler <= wdt_prescaler + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_wdt_timeout <= 1'b0;
        end else if (i_clk_en) begin
            o_wdt_timeout <= wdt_expire;
        end
    end

endmodule : ssxs_exec

// ---- verification/ssxs_exec_checker.sv ----
/* Port checker for ssxs_exec: bus handshake, sleep entry, direction loads.
   Assumes no request while i_clk_en is low, and one request at a time. */
`timescale 1ns/10ps
module ssxs_checker
    import ssxs_pkg::*;
(
    input wire logic              i_clk_sys,
    input wire logic              i_nrst,
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic              i_avs_read,
    input wire logic              i_avs_write,
    input wire logic [BUS_DW-1:0] i_avs_writedata,
    input wire logic [BUS_DW-1:0] o_avs_readdata,
    input wire logic              o_avs_waitrequest,
    input wire logic              o_sleep,
    input wire logic [7:0]        o_port_a_direction,
    input wire logic [7:0]        o_port_b_direction,
    input wire logic [7:0]        o_port_c_direction,
    input wire logic              o_wdt_timeout
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    wire logic       cmd_go;
    wire logic [3:0] op;
    wire logic       dir_go;
    assign cmd_go = i_avs_write && !o_avs_waitrequest && i_avs_address == ADDR_CMD && !o_sleep;
    assign op     = i_avs_writedata[19:16];
    assign dir_go = cmd_go && op == OP_DIR_LOAD;

    a_wait_one_cycle: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("waitrequest held too long");
    a_wait_idle_low: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
        else $error("waitrequest without request");
    a_sleep_entry: assert property (cmd_go && op == OP_SLEEP |=> o_sleep)
        else $error("sleep not entered");
    a_sleep_cause: assert property ($rose(o_sleep) |-> $past(cmd_go && op == OP_SLEEP))
        else $error("sleep without command");
    a_dir_a_load: assert property ($changed(o_port_a_direction) |->
        $past(dir_go && i_avs_writedata[14:8] == DIR_SEL_A)) else $error("port a changed");
    a_dir_b_load: assert property ($changed(o_port_b_direction) |->
        $past(dir_go && i_avs_writedata[14:8] == DIR_SEL_B)) else $error("port b changed");
    a_dir_c_load: assert property ($changed(o_port_c_direction) |->
        $past(dir_go && i_avs_writedata[14:8] == DIR_SEL_C)) else $error("port c changed");
    a_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest
        && i_avs_address == 10'h100 |-> o_avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_timeout_pulse: assert property (o_wdt_timeout |=> !o_wdt_timeout)
        else $error("timeout pulse too long");
endmodule : ssxs_checker

bind ssxs_exec ssxs_checker u_chk (.i_clk_sys, .i_nrst, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .o_sleep,
    .o_port_a_direction, .o_port_b_direction, .o_port_c_direction, .o_wdt_timeout);

// ---- verification/ssxs_exec_bench.sv ----
/* Self-checking bench for ssxs_exec: random datapath commands, sleep, wake
   and watchdog expiry. Assumes the package and checker are compiled first. */
`timescale 1ns/10ps
module ssxs_exec_bench
    import ssxs_pkg::*;
;
    logic        i_clk_sys, i_nrst, rd, wr, wake, dst, fop, ce;
    logic [9:0]  adr;
    logic [31:0] wd, rdata, seed;
    logic [3:0]  op;
    logic [6:0]  fa;
    logic [7:0]  w, f, k, acc_exp, m_dir [3];
    logic [2:0]  st;
    logic [10:0] e;
    wire logic [31:0] q;
    wire logic        wreq, slp, tmo;
    wire logic [7:0]  da, db, dc_o;
    int          n_mismatch, n_tests, cyc, n;

    ssxs_exec #(.WDT_PRESCALE(2)) dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
        .i_clk_en(ce), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(q),
        .o_avs_waitrequest(wreq), .i_wake(wake), .o_sleep(slp), .o_port_a_direction(da),
        .o_port_b_direction(db), .o_port_c_direction(dc_o), .o_wdt_timeout(tmo));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // Returns {z, nibble carry, carry, result}
    function automatic logic [10:0] exp_op(input logic [3:0] o, input logic [7:0] a_w, a_f,
                                           a_k, input logic [2:0] s_in);
        logic [7:0] a, r;
        logic [8:0] b;
        logic [4:0] bl;
        logic [2:0] s;
        s = s_in;
        a = (o == OP_LIT_MINUS || o == OP_LIT_XOR) ? a_k : a_f;
        b = {1'b0, a_w} + {8'h00, o == OP_FILE_MINUS_B && !s_in[0]};
        bl = {1'b0, a_w[3:0]} + {4'h0, o == OP_FILE_MINUS_B && !s_in[0]};
        r = a ^ a_w;
        if (o == OP_NIBBLE_EX) r = {a_f[3:0], a_f[7:4]};
        if (o <= OP_FILE_MINUS_B) begin
            r = a - b[7:0];
            s[0] = {1'b0, a} >= b;
            s[1] = {1'b0, a[3:0]} >= bl;
        end
        if (o != OP_NIBBLE_EX) s[2] = (r == 8'h00);
        return {s, r};
    endfunction : exp_op

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Entered just after a rising edge; holds the request until waitrequest is low
    task automatic bus(input logic wr_n, input logic [9:0] a, input logic [31:0] d);
        adr <= a;
        wr <= wr_n;
        rd <= !wr_n;
        wd <= d;
        do @(posedge i_clk_sys); while (wreq !== 1'b0);
        rdata = q;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge i_clk_sys);
    endtask : bus

    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rdata, exp);
    endtask : rd_chk

    task automatic pin_chk(input logic [31:0] got_now, input logic [31:0] exp);
        @(negedge i_clk_sys);
        chk(got_now, exp);
        @(posedge i_clk_sys);
    endtask : pin_chk

    task automatic stop_test;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test;
        end
    end

    initial begin
        {i_nrst, rd, wr, wake, adr, wd, acc_exp} = '0;
        {n_mismatch, n_tests, cyc} = '0;
        ce = 1'b1;
        seed = 32'h0000_005C;
        m_dir = '{8'hFF, 8'hFF, 8'hFF};
        repeat (4) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        @(posedge i_clk_sys);
        rd_chk(ADDR_STATUS, 32'h0000_0018);
        rd_chk(ADDR_DIR, 32'h00FF_FFFF);
        bus(1'b1, 10'h100, 32'h0000_00AA);
        rd_chk(10'h100, 32'h0000_0000);
        for (int i = 0; i < 150; i++) begin
            seed = xs(seed);
            op = (seed[26:24] == 3'h0) ? OP_DIR_LOAD : {1'b0, seed[26:24]};
            {w, f, k} = seed[31:8];
            fa = (op == OP_DIR_LOAD) ? {5'h01, seed[1:0]} : seed[6:0];
            dst = seed[7];
            st = seed[4:2];
            if (i < 7) begin
                op = 4'(i + 1);
                {w, f, k} = 24'h5A5A_5A;
            end
            bus(1'b1, ADDR_ACC, {24'h00_0000, w});
            bus(1'b1, ADDR_FILE_BASE + {fa, 2'b00}, {24'h00_0000, f});
            bus(1'b1, ADDR_STATUS, {27'h000_0003, st});
            bus(1'b1, ADDR_CMD, {12'h000, op, dst, fa, k});
            e = exp_op(op, w, f, k, st);
            if (op == OP_DIR_LOAD) begin
                e = {st, w};
                if (fa inside {DIR_SEL_A, DIR_SEL_B, DIR_SEL_C}) m_dir[fa - DIR_SEL_A] = w;
            end
            fop = op inside {OP_FILE_MINUS, OP_FILE_MINUS_B, OP_NIBBLE_EX, OP_FILE_XOR};
            acc_exp = (fop && dst) ? w : e[7:0];
            rd_chk(ADDR_ACC, {24'h00_0000, acc_exp});
            rd_chk(ADDR_FILE_BASE + {fa, 2'b00}, {24'h00_0000, (fop && dst) ? e[7:0] : f});
            rd_chk(ADDR_STATUS, {27'h000_0003, e[10:8]});
            pin_chk({8'h00, dc_o, db, da}, {8'h00, m_dir[2], m_dir[1], m_dir[0]});
        end
        bus(1'b1, ADDR_WDT_CTRL, 32'h0000_0001);
        ce <= 1'b0;
        repeat (40) @(posedge i_clk_sys);
        ce <= 1'b1;
        // Frozen watchdog: prescaler stopped at 1, counter still 0
        rd_chk(ADDR_WDT_COUNT, 32'h0000_0100);
        bus(1'b1, ADDR_WDT_CTRL, 32'h0000_0000);
        bus(1'b1, ADDR_STATUS, 32'h0000_001D);
        bus(1'b1, ADDR_CMD, {12'h000, OP_SLEEP, 16'h0000});
        pin_chk(slp, 32'h0000_0001);
        rd_chk(ADDR_STATUS, 32'h0000_0035);
        rd_chk(ADDR_WDT_COUNT, 32'h0000_0000);
        bus(1'b1, ADDR_CMD, {12'h000, OP_LIT_XOR, 16'h00FF});
        rd_chk(ADDR_ACC, {24'h00_0000, acc_exp});
        wake <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
        wake <= 1'b0;
        pin_chk(slp, 32'h0000_0000);
        bus(1'b1, ADDR_WDT_CTRL, 32'h0000_0001);
        bus(1'b1, ADDR_CMD, {12'h000, OP_SLEEP, 16'h0000});
        for (n = 0; n < 1000 && tmo !== 1'b1; n++) @(negedge i_clk_sys);
        chk(tmo, 32'h0000_0001);
        @(posedge i_clk_sys);
        bus(1'b1, ADDR_WDT_CTRL, 32'h0000_0000);
        rd_chk(ADDR_STATUS, 32'h0000_0005);
        stop_test;
    end
endmodule : ssxs_exec_bench
